// ---- design/uft_consts.vh ----
// Named constants for the serial frame transmitter channel.
// Assumes inclusion by bare name from the design modules.
`ifndef UFT_CONSTS_VH
`define UFT_CONSTS_VH

// Register byte offsets, one 32-bit word each
`define UFT_OFF_DATA 8'h00
`define UFT_OFF_CTRL 8'h04
`define UFT_OFF_FMT 8'h08
`define UFT_OFF_STAT 8'h0C
`define UFT_OFF_BAUD 8'h10

// Control register fields
`define UFT_CTRL_TXEN 0
`define UFT_CTRL_NINTH 1
`define UFT_CTRL_DBL 2
`define UFT_CTRL_RXEN 3

// Format register fields
`define UFT_FMT_SIZE_LO 0
`define UFT_FMT_SIZE_HI 2
`define UFT_FMT_PAR_LO 4
`define UFT_FMT_PAR_HI 5
`define UFT_FMT_STOP2 6
`define UFT_FMT_SYNC 7
`define UFT_FMT_POL 8
`define UFT_FMT_MASTER 9

// Status register fields
`define UFT_STAT_EMPTY 0
`define UFT_STAT_TXC 1
`define UFT_STAT_RXC 2
`define UFT_STAT_FE 3

// Character size codes
`define UFT_SIZE_NINE 3'h7
`define UFT_BITS_BASE 4'h5
`define UFT_BITS_EIGHT 4'h8
`define UFT_BITS_NINE 4'h9

// Parity mode: upper bit enables, lower bit selects odd
`define UFT_PAR_EN 1
`define UFT_PAR_ODD 0

// Baud tick divider end values (16 and 8 ticks per bit)
`define UFT_DIVMAX_NORM 4'hF
`define UFT_DIVMAX_DBL 4'h7
`define UFT_HALF_NORM 4'h8
`define UFT_HALF_DBL 4'h4

// Reset values
`define UFT_RST_FMT 10'h006
`define UFT_RST_BAUD 12'h000

`endif

// ---- design/uft_baud_gen.v ----
// Baud rate down-counter producing one tick per reload at zero.
// Assumes a divisor held steady by the register file.
module uft_baud_gen #(
  parameter DIV_W = 12
) (
  input wire pclk,
  input wire presetn,
  input wire ce,
  input wire [DIV_W-1:0] divisor,
  input wire reload,
  output reg tick
);
  reg [DIV_W-1:0] cnt_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= {DIV_W{1'b0}};
      tick <= 1'b0;
    end else if (ce) begin
      if (reload) begin
        cnt_q <= divisor;
        tick <= 1'b0;
      end else if (cnt_q == {DIV_W{1'b0}}) begin
        cnt_q <= divisor;
        tick <= 1'b1;
      end else begin
        cnt_q <= cnt_q - {{(DIV_W-1){1'b0}}, 1'b1};
        tick <= 1'b0;
      end
    end
  end
endmodule // uft_baud_gen

// ---- design/uft_edge_sync.v ----
// Two-stage synchroniser and edge detector for the external transfer clock.
// Assumes the remote clock is slower than a quarter of pclk.
module uft_edge_sync (
  input wire pclk,
  input wire presetn,
  input wire ce,
  input wire clk_in,
  output wire rise,
  output wire fall
);
  reg s1_q;
  reg s2_q;
  reg s3_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else if (ce) begin
      s1_q <= clk_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Edges seen two pclk cycles after the pin moves
  assign rise = s2_q & ~s3_q;
  assign fall = ~s2_q & s3_q;
endmodule // uft_edge_sync

// ---- design/uft_top.v ----
// Serial frame transmitter channel with APB registers and a frame checker.
// Assumes APB master on pclk; pin inputs are synchronous except the slave clock.
`include "uft_consts.vh"

module uft_top #(
  parameter DIV_W = 12
) (
  input wire pclk,
  input wire presetn,
  input wire ce,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire serial_in_pin,
  output reg serial_out_pin,
  output reg serial_out_oe,
  input wire transfer_clock_in,
  output reg transfer_clock_out,
  output reg transfer_clock_oe
);
  localparam TX_IDLE = 3'h0;
  localparam TX_START = 3'h1;
  localparam TX_DATA = 3'h2;
  localparam TX_PAR = 3'h3;
  localparam TX_STOP = 3'h4;
  localparam RX_IDLE = 1'b0;
  localparam RX_BUSY = 1'b1;

  reg txen_q, ninth_q, dbl_q, rxen_q;
  reg [9:0] fmt_q;
  reg [DIV_W-1:0] div_q;
  reg [8:0] buf_q;
  reg buf_full_q, txc_q;
  reg [2:0] tx_st_q;
  reg [8:0] tsh_q;
  reg tpar_q;
  reg [3:0] tcnt_q, tdiv_q;
  reg rx_st_q, rx_prev_q;
  reg [3:0] rbit_q, rdiv_q;
  reg [8:0] rsh_q, rxd_q;
  reg rxc_q, fe_q;
  reg [31:0] rmux;
  reg hit;

  wire [2:0] size = fmt_q[`UFT_FMT_SIZE_HI:`UFT_FMT_SIZE_LO];
  wire par_en = fmt_q[`UFT_FMT_PAR_HI];
  wire par_odd = fmt_q[`UFT_FMT_PAR_LO];
  wire stop2 = fmt_q[`UFT_FMT_STOP2];
  wire sync = fmt_q[`UFT_FMT_SYNC];
  wire pol = fmt_q[`UFT_FMT_POL];
  wire master = fmt_q[`UFT_FMT_MASTER];

  // Shared by transmitter and receiver; changing it mid-frame corrupts both
  wire [3:0] nbits = (size == `UFT_SIZE_NINE) ? `UFT_BITS_NINE :
                     (size[2] ? `UFT_BITS_EIGHT : `UFT_BITS_BASE + {2'b00, size[1:0]});
  wire [8:0] dmask = ~(9'h1FF << nbits);
  wire [3:0] div_max = dbl_q ? `UFT_DIVMAX_DBL : `UFT_DIVMAX_NORM;
  wire [3:0] half = dbl_q ? `UFT_HALF_DBL : `UFT_HALF_NORM;

  // APB: one wait state, so pready comes from a flop
  wire acc = psel & penable & pready;
  wire wr = acc & pwrite;
  wire rd = acc & ~pwrite;
  wire wr_data = wr & (paddr == `UFT_OFF_DATA);
  wire wr_baud = wr & (paddr == `UFT_OFF_BAUD);
  wire rd_data = rd & (paddr == `UFT_OFF_DATA);
  wire wr_stat = wr & (paddr == `UFT_OFF_STAT);

  always @* begin
    rmux = 32'h00000000;
    hit = 1'b1;
    case (paddr)
      `UFT_OFF_DATA: rmux[8:0] = rxd_q;
      `UFT_OFF_CTRL: begin
        rmux[`UFT_CTRL_TXEN] = txen_q;
        rmux[`UFT_CTRL_NINTH] = ninth_q;
        rmux[`UFT_CTRL_DBL] = dbl_q;
        rmux[`UFT_CTRL_RXEN] = rxen_q;
      end
      `UFT_OFF_FMT: rmux[9:0] = fmt_q;
      `UFT_OFF_STAT: begin
        rmux[`UFT_STAT_EMPTY] = ~buf_full_q;
        rmux[`UFT_STAT_TXC] = txc_q;
        rmux[`UFT_STAT_RXC] = rxc_q;
        rmux[`UFT_STAT_FE] = fe_q;
      end
      `UFT_OFF_BAUD: rmux[DIV_W-1:0] = div_q;
      default: hit = 1'b0;
    endcase
  end

  wire tick;
  uft_baud_gen #(.DIV_W(DIV_W)) u_baud (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .divisor(div_q),
    .reload(wr_baud),
    .tick(tick)
  );

  wire ext_rise, ext_fall;
  uft_edge_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .clk_in(transfer_clock_in),
    .rise(ext_rise),
    .fall(ext_fall)
  );

  // Master clock toggles per baud tick, giving the divide by two
  wire tx_busy = (tx_st_q != TX_IDLE) | buf_full_q;
  wire mrun = sync & master & (txen_q | tx_busy | rxen_q);
  wire m_edge = mrun & tick;
  wire m_rise = m_edge & ~transfer_clock_out;
  wire m_fall = m_edge & transfer_clock_out;
  wire e_rise = master ? m_rise : ext_rise;
  wire e_fall = master ? m_fall : ext_fall;
  wire chg_ev = sync & (pol ? e_fall : e_rise);
  wire smp_ev = sync & (pol ? e_rise : e_fall);

  wire bit_adv = sync ? chg_ev : (tick & (tdiv_q == div_max));
  wire last_stop = ~stop2 | (tcnt_q == 4'h1);
  wire stop_end = (tx_st_q == TX_STOP) & bit_adv & last_stop;
  wire idle_go = (tx_st_q == TX_IDLE) & (sync ? chg_ev : 1'b1);
  wire load = buf_full_q & (idle_go | stop_end);
  wire [8:0] ld_data = buf_q & dmask;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      txen_q <= 1'b0;
      ninth_q <= 1'b0;
      dbl_q <= 1'b0;
      rxen_q <= 1'b0;
      fmt_q <= `UFT_RST_FMT;
      div_q <= `UFT_RST_BAUD;
      buf_q <= 9'h000;
      buf_full_q <= 1'b0;
      txc_q <= 1'b0;
    end else if (ce) begin
      pready <= psel & penable & ~pready;
      if (psel & penable & ~pready) begin
        prdata <= pwrite ? 32'h00000000 : rmux;
        pslverr <= ~hit;
      end
      if (wr & (paddr == `UFT_OFF_CTRL)) begin
        txen_q <= pwdata[`UFT_CTRL_TXEN];
        ninth_q <= pwdata[`UFT_CTRL_NINTH];
        dbl_q <= pwdata[`UFT_CTRL_DBL];
        rxen_q <= pwdata[`UFT_CTRL_RXEN];
      end
      if (wr & (paddr == `UFT_OFF_FMT))
        fmt_q <= pwdata[9:0];
      if (wr_baud)
        div_q <= pwdata[DIV_W-1:0];
      // Ninth bit is captured from the control register at this write
      if (wr_data) begin
        buf_q <= {ninth_q, pwdata[7:0]};
        buf_full_q <= 1'b1;
      end else if (load) begin
        buf_full_q <= 1'b0;
      end
      // Setting wins over a clearing write in the same cycle
      if (stop_end & ~buf_full_q)
        txc_q <= 1'b1;
      else if (wr_stat & pwdata[`UFT_STAT_TXC])
        txc_q <= 1'b0;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_st_q <= TX_IDLE;
      tsh_q <= 9'h000;
      tpar_q <= 1'b0;
      tcnt_q <= 4'h0;
      tdiv_q <= 4'h0;
      serial_out_pin <= 1'b1;
      serial_out_oe <= 1'b0;
      transfer_clock_out <= 1'b0;
      transfer_clock_oe <= 1'b0;
    end else if (ce) begin
      // Disabling takes effect only once buffer and shifter drain
      serial_out_oe <= txen_q | tx_busy;
      transfer_clock_oe <= mrun;
      if (m_edge)
        transfer_clock_out <= ~transfer_clock_out;
      else if (!mrun)
        transfer_clock_out <= pol;
      if (load) begin
        tdiv_q <= 4'h0;
      end else if (tick) begin
        tdiv_q <= (tdiv_q == div_max) ? 4'h0 : tdiv_q + 4'h1;
      end
      if (load) begin
        tx_st_q <= TX_START;
        tsh_q <= ld_data;
        tpar_q <= (^ld_data) ^ par_odd;
        serial_out_pin <= 1'b0;
        tcnt_q <= 4'h0;
      end else if (bit_adv) begin
        case (tx_st_q)
          TX_START: begin
            tx_st_q <= TX_DATA;
            serial_out_pin <= tsh_q[0];
            tsh_q <= {1'b0, tsh_q[8:1]};
            tcnt_q <= 4'h1;
          end
          TX_DATA: begin
            if (tcnt_q == nbits) begin
              tcnt_q <= 4'h0;
              if (par_en) begin
                tx_st_q <= TX_PAR;
                serial_out_pin <= tpar_q;
              end else begin
                tx_st_q <= TX_STOP;
                serial_out_pin <= 1'b1;
              end
            end else begin
              serial_out_pin <= tsh_q[0];
              tsh_q <= {1'b0, tsh_q[8:1]};
              tcnt_q <= tcnt_q + 4'h1;
            end
          end
          TX_PAR: begin
            tx_st_q <= TX_STOP;
            serial_out_pin <= 1'b1;
            tcnt_q <= 4'h0;
          end
          TX_STOP: begin
            if (last_stop) begin
              tx_st_q <= TX_IDLE;
              serial_out_pin <= 1'b1;
            end else begin
              tcnt_q <= 4'h1;
            end
          end
          default: begin
            tx_st_q <= TX_IDLE;
            serial_out_pin <= 1'b1;
          end
        endcase
      end
    end
  end

  // Receiver, kept to what the frame error check needs
  wire rsamp = sync ? smp_ev : (tick & (rdiv_q == div_max));
  wire [3:0] rx_stop_idx = nbits + 4'h1 + {3'b000, par_en};

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_st_q <= RX_IDLE;
      rx_prev_q <= 1'b1;
      rbit_q <= 4'h0;
      rdiv_q <= 4'h0;
      rsh_q <= 9'h000;
      rxd_q <= 9'h000;
      rxc_q <= 1'b0;
      fe_q <= 1'b0;
    end else if (ce) begin
      rx_prev_q <= serial_in_pin;
      if (tick)
        rdiv_q <= (rdiv_q == div_max) ? 4'h0 : rdiv_q + 4'h1;
      if (rd_data)
        rxc_q <= 1'b0;
      case (rx_st_q)
        RX_IDLE: begin
          if (rxen_q & sync & smp_ev & ~serial_in_pin) begin
            rx_st_q <= RX_BUSY;
            rbit_q <= 4'h1;
          end else if (rxen_q & ~sync & rx_prev_q & ~serial_in_pin) begin
            rx_st_q <= RX_BUSY;
            rbit_q <= 4'h0;
            rdiv_q <= half;
          end
        end
        RX_BUSY: begin
          if (rsamp) begin
            if (rbit_q == 4'h0) begin
              // A start bit gone high at mid-bit was a glitch
              if (serial_in_pin)
                rx_st_q <= RX_IDLE;
              else
                rbit_q <= 4'h1;
            end else if (rbit_q <= nbits) begin
              rsh_q <= {serial_in_pin, rsh_q[8:1]};
              rbit_q <= rbit_q + 4'h1;
            end else if (rbit_q == rx_stop_idx) begin
              fe_q <= ~serial_in_pin;
              rxd_q <= rsh_q >> (`UFT_BITS_NINE - nbits);
              rxc_q <= 1'b1;
              rx_st_q <= RX_IDLE;
            end else begin
              rbit_q <= rbit_q + 4'h1;
            end
          end
        end
        default: rx_st_q <= RX_IDLE;
      endcase
    end
  end
endmodule // uft_top

// ---- verif/uft_monitor.sv ----
// Port checker for the serial channel: APB handshake and serial line.
// Assumes binding into uft_top; sees only its ports.
`include "uft_consts.vh"
module uft_monitor (
  input wire pclk,
  input wire presetn,
  input wire ce,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire serial_out_pin,
  input wire serial_out_oe,
  input wire transfer_clock_out,
  input wire transfer_clock_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable && pready;
  wire bad = (paddr > `UFT_OFF_BAUD) || (paddr[1:0] != 2'h0);
  AST_READY_WAIT: assert property (psel && penable && !pready && ce |=> pready)
    else $error("ready missing after wait");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("ready too long");
  AST_READY_CAUSE: assert property (pready |-> $past(penable))
    else $error("ready without access");
  AST_UNMAPPED: assert property (acc && bad |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  AST_IDLE_HIGH: assert property (!serial_out_oe |-> serial_out_pin)
    else $error("line low while idle");
  AST_TXEN_OE: assert property (acc && pwrite && paddr == `UFT_OFF_CTRL && pwdata[0]
      |-> ##[1:3] serial_out_oe)
    else $error("output not taken over");
  // Shortest legal bit is four cycles, so three steady cycles is safe
  AST_BIT_HOLD: assert property ($changed(serial_out_pin) && !transfer_clock_oe
      |=> $stable(serial_out_pin) [*3])
    else $error("bit too short");
  AST_SYNC_EDGE: assert property (transfer_clock_oe && $changed(serial_out_pin)
      |-> ##[0:1] $changed(transfer_clock_out))
    else $error("data moved off clock edge");
endmodule // uft_monitor

bind uft_top uft_monitor mon (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .serial_out_pin(serial_out_pin),
  .serial_out_oe(serial_out_oe), .transfer_clock_out(transfer_clock_out),
  .transfer_clock_oe(transfer_clock_oe));

// ---- verif/uft_remote.sv ----
// Remote serial transceiver: decodes frames and sends frames.
// Assumes one caller per direction at a time.
module uft_remote (
  input wire logic pclk,
  input wire logic serial_out_pin,
  input wire logic transfer_clock_out,
  output logic serial_in_pin,
  output logic clock_drive
);
  timeunit 1ns;
  timeprecision 1ns;
  initial serial_in_pin = 1'b1;
  initial clock_drive = 1'b0;
  // Sync sample edge moves the clock to the polarity level
  task automatic step(input bit sy, input bit pol, input int per);
    logic p;
    int k;
    p = transfer_clock_out;
    if (!sy) repeat (per) @(negedge pclk);
    else for (k = 0; k < 64; k++) begin
      @(negedge pclk);
      if (transfer_clock_out === pol && p !== pol) break;
      p = transfer_clock_out;
    end
  endtask
  task automatic get_frame(input int n, input int per, input bit sy, input bit pol,
      output logic [12:0] v);
    int i;
    int k;
    v = 13'h0;
    for (k = 0; k < 1000 && serial_out_pin !== 1'b0; k++) step(sy, pol, 1);
    if (!sy) step(1'b0, pol, per / 2);
    v[0] = serial_out_pin;
    for (i = 1; i < n; i++) begin
      step(sy, pol, per);
      v[i] = serial_out_pin;
    end
  endtask
  task automatic send(input logic [12:0] v, input int n, input int per);
    int i;
    for (i = 0; i < n; i++) begin
      @(posedge pclk);
      serial_in_pin <= v[i];
      repeat (per - 1) @(posedge pclk);
    end
    @(posedge pclk);
    serial_in_pin <= 1'b1;
  endtask
  // Remote master in slave mode: eight-cycle clock, under a quarter of pclk;
  // one extra clock after the last bit lets the shifter finish its stop bit
  task automatic get_slave(input int n, output logic [12:0] v);
    int i;
    int k;
    v = 13'h0;
    i = 0;
    for (k = 0; k < 64 && i <= n; k++) begin
      @(posedge pclk);
      clock_drive <= 1'b1;
      repeat (4) @(posedge pclk);
      clock_drive <= 1'b0;
      if (i > 0 || serial_out_pin === 1'b0) begin
        if (i < n) v[i] = serial_out_pin;
        i++;
      end
      repeat (3) @(posedge pclk);
    end
  endtask
endmodule // uft_remote

// ---- verif/testbench.sv ----
// Self-checking bench for the serial frame channel.
// Assumes uft_top, uft_remote and the bound checker are compiled first.
`include "uft_consts.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] r;
  logic e;
  logic [12:0] got, exp;
  logic [8:0] d;
  logic [2:0] sz;
  logic [1:0] pm;
  logic s2, dbl, sy, pol;
  wire [31:0] prdata;
  wire pready, pslverr, sout, soe, ckout, ckoe, sin, ckin;
  int num_errors = 0;
  int total_checks = 0;
  int t, n, nb, per, dv;
  int szt[5] = '{0, 1, 2, 3, 7};
  int pmt[3] = '{0, 2, 3};
  always #20 pclk = ~pclk;
  uft_top DUT (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serial_in_pin(sin), .serial_out_pin(sout), .serial_out_oe(soe),
    .transfer_clock_in(ckin), .transfer_clock_out(ckout), .transfer_clock_oe(ckoe));
  uft_remote partner (.pclk(pclk), .serial_out_pin(sout), .transfer_clock_out(ckout),
    .serial_in_pin(sin), .clock_drive(ckin));
  task automatic stop_test;
    if (num_errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic fail;
    num_errors++;
    stop_test;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    total_checks++;
    if (seen !== want) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 16; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k == 16) fail;
  endtask
  task automatic wait_stat(input int b);
    int k;
    for (k = 0; k < 3000; k++) begin
      apb(1'b0, `UFT_OFF_STAT, 32'h0);
      if (r[b] === 1'b1) break;
    end
    if (k == 3000) fail;
  endtask
  // Bits beyond the frame stay zero to match what the decoder leaves
  function automatic logic [12:0] frame(input logic [8:0] c, input int w, input logic [1:0] p,
      input logic two, output int len);
    logic [12:0] v;
    int i;
    v = 13'h1FFE;
    for (i = 0; i < w; i++) v[i + 1] = c[i];
    if (p[1]) v[w + 1] = ^(c & ~(9'h1FF << w)) ^ p[0];
    len = w + 2 + p[1] + two;
    return v & ~(13'h1FFF << len);
  endfunction
  initial begin
    void'($urandom(32'h2AF4D190));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `UFT_OFF_FMT, 32'h0);
    chk(r, 32'h006);
    apb(1'b0, `UFT_OFF_STAT, 32'h0);
    chk(r, 32'h1);
    apb(1'b1, 8'h40, 32'hFFFFFFFF);
    chk(e, 1'b1);
    apb(1'b0, 8'h40, 32'h0);
    chk(r, 32'h0);
    for (t = 0; t < 12; t++) begin
      sz = 3'(szt[t % 5]);
      nb = (sz == 3'h7) ? 9 : sz + 5;
      pm = 2'(pmt[t % 3]);
      sy = (t >= 9);
      pol = 1'(t);
      s2 = 1'($urandom);
      dbl = sy ? 1'b0 : 1'($urandom);
      dv = $urandom % 3;
      d = 9'($urandom);
      per = (dbl ? 8 : 16) * (dv + 1);
      exp = frame(d, nb, pm, s2, n);
      apb(1'b1, `UFT_OFF_BAUD, dv);
      apb(1'b1, `UFT_OFF_FMT, {22'h0, sy, pol, sy, s2, pm, 1'b0, sz});
      apb(1'b1, `UFT_OFF_CTRL, {29'h0, dbl, d[8], 1'b1});
      apb(1'b1, `UFT_OFF_STAT, 32'h2);
      chk(ckoe, sy);
      fork
        partner.get_frame(n, per, sy, pol, got);
        apb(1'b1, `UFT_OFF_DATA, {23'h0, d});
      join
      chk(got, exp);
      wait_stat(1);
    end
    apb(1'b1, `UFT_OFF_FMT, 32'h006);
    apb(1'b1, `UFT_OFF_BAUD, 32'h0);
    apb(1'b1, `UFT_OFF_CTRL, 32'h1);
    apb(1'b1, `UFT_OFF_STAT, 32'h2);
    fork
      begin
        partner.get_frame(10, 16, 1'b0, 1'b0, got);
        chk(got, frame(9'h0A5, 8, 2'h0, 1'b0, n));
        partner.get_frame(10, 16, 1'b0, 1'b0, got);
        chk(got, frame(9'h13C, 8, 2'h0, 1'b0, n));
      end
      begin
        apb(1'b1, `UFT_OFF_DATA, 32'hA5);
        apb(1'b1, `UFT_OFF_DATA, 32'h13C);
        apb(1'b0, `UFT_OFF_STAT, 32'h0);
        chk(r[0], 1'b0);
        apb(1'b1, `UFT_OFF_CTRL, 32'h0);
        chk(soe, 1'b1);
      end
    join
    wait_stat(1);
    repeat (2) @(posedge pclk);
    chk(soe, 1'b0);
    // Slave mode: the remote side supplies the transfer clock
    apb(1'b1, `UFT_OFF_FMT, 32'h0A3);
    apb(1'b1, `UFT_OFF_CTRL, 32'h1);
    apb(1'b1, `UFT_OFF_STAT, 32'h2);
    chk(ckoe, 1'b0);
    d = 9'($urandom);
    fork
      partner.get_slave(11, got);
      apb(1'b1, `UFT_OFF_DATA, {23'h0, d});
    join
    chk(got, frame(d, 8, 2'h2, 1'b0, n));
    wait_stat(1);
    apb(1'b1, `UFT_OFF_FMT, 32'h046);
    apb(1'b1, `UFT_OFF_CTRL, 32'h8);
    for (t = 0; t < 2; t++) begin
      d = 9'($urandom);
      partner.send({2'h0, t == 0, t == 1, d[7:0], 1'b0}, 11, 16);
      wait_stat(2);
      chk(r[3], t == 0);
      apb(1'b0, `UFT_OFF_DATA, 32'h0);
      chk(r[7:0], d[7:0]);
    end
    stop_test;
  end
endmodule // testbench
